//--- lipd_pkg.sv
`default_nettype none
package lipd_pkg;
	// Configuration byte offsets
	localparam logic [7:0] OFS_TCTRL  = 8'h68;
	localparam logic [7:0] OFS_TBASE0 = 8'h69;
	localparam logic [7:0] OFS_TBASE1 = 8'h6a;
	localparam logic [7:0] OFS_TBASE2 = 8'h6b;
	localparam logic [7:0] OFS_CTRL1  = 8'h6c;
	localparam logic [7:0] OFS_CTRL2  = 8'h6d;
	localparam logic [7:0] OFS_CTRL3  = 8'h6e;
	localparam logic [7:0] OFS_CTRL4  = 8'h6f;
	localparam logic [7:0] OFS_SVID0  = 8'h70;
	localparam logic [7:0] OFS_SVID1  = 8'h71;
	localparam logic [7:0] OFS_SID0   = 8'h72;
	localparam logic [7:0] OFS_SID1   = 8'h73;
	localparam logic [7:0] OFS_ROMSEL = 8'h75;
	localparam logic [7:0] OFS_FW1    = 8'h76;
	localparam logic [7:0] OFS_FW2    = 8'h77;
	localparam logic [7:0] OFS_FW3    = 8'h7c;
	localparam logic [7:0] OFS_FW4    = 8'h7d;
	localparam logic [7:0] OFS_FW5    = 8'h7e;
	localparam logic [7:0] OFS_FW6    = 8'h7f;
	// Reset values and writable masks
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_HALF   = 16'h0000;
	localparam logic [21:0] RST_TBASE  = 22'h000000;
	localparam logic [7:0]  TCTRL_MASK = 8'h8f;
	localparam logic [3:0]  FW6_HI_RO  = 4'h0;
	// Field positions
	localparam int TCTRL_EN   = 7;
	localparam int C1_ONBOARD = 7;
	localparam int C1_MSS_EN  = 6;
	localparam int C1_MSS_LO  = 4;
	localparam int C1_APIC    = 3;
	localparam int C1_ROM     = 2;
	localparam int C1_PSEL1   = 1;
	localparam int C1_PSEL0   = 0;
	localparam int C2_FLOPPY  = 7;
	localparam int C2_PAR_EN  = 6;
	localparam int C2_PAR_LO  = 4;
	localparam int C2_GAME    = 3;
	localparam int C2_MIDI_EN = 2;
	localparam int C2_MIDI_LO = 0;
	localparam int C3_SERB_EN = 7;
	localparam int C3_SERB_LO = 4;
	localparam int C3_SERA_EN = 3;
	localparam int C3_SERA_LO = 0;
	localparam int C4_SPI     = 7;
	localparam int C4_TRUST   = 6;
	localparam int C4_PSEL23  = 5;
	localparam int C4_RSTPORT = 4;
	localparam int C4_FLOPSEC = 3;
	localparam int C4_SND_EN  = 2;
	localparam int C4_SND_LO  = 0;
	// Fixed I/O ranges
	localparam logic [15:0] ONBOARD_HI = 16'h00ff;
	localparam logic [15:0] RSTPORT    = 16'h0cf9;
	localparam logic [15:0] GAME_LO    = 16'h0200;
	localparam logic [15:0] GAME_HI    = 16'h0207;
	localparam logic [15:0] FLOP_PRI   = 16'h03f0;
	localparam logic [15:0] FLOP_SEC   = 16'h0370;
	localparam logic [15:0] FLOP_LEN   = 16'h0007;
	localparam logic [15:0] MSS_LEN    = 16'h0007;
	localparam logic [15:0] SER_LEN    = 16'h0007;
	localparam logic [15:0] MIDI_BASE  = 16'h0300;
	localparam logic [15:0] MIDI_LEN   = 16'h0003;
	localparam logic [15:0] SND_BASE   = 16'h0220;
	localparam logic [15:0] SND_LEN_A  = 16'h000f;
	localparam logic [15:0] SND_OFS_B  = 16'h0010;
	localparam logic [15:0] SND_LEN_B  = 16'h0003;
	localparam logic [15:0] MSS_BASE [4] = '{16'h0530, 16'h0604,
		16'h0e80, 16'h0f40};
	localparam logic [15:0] SER_BASE [8] = '{16'h03f8, 16'h02f8,
		16'h0220, 16'h0228, 16'h0238, 16'h02e8, 16'h0338, 16'h03e8};
	localparam logic [15:0] PAR_LO_A [3] = '{16'h03bc, 16'h0378, 16'h0278};
	localparam logic [15:0] PAR_HI_A [3] = '{16'h03bf, 16'h037f, 16'h027f};
	localparam logic [15:0] PAR_LO_B [3] = '{16'h07bc, 16'h0778, 16'h0678};
	localparam logic [15:0] PAR_HI_B [3] = '{16'h07be, 16'h077a, 16'h067a};
	// Firmware memory windows and the reserved parallel range code
	localparam logic [7:0]  ROM_TOP   = 8'hff;
	localparam logic [14:0] LEGACY_HI = 15'h0007;
	localparam logic [1:0]  PAR_RSVD  = 2'b11;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lipd_cfg_t;

	typedef struct packed {
		logic       global_pos;
		logic       mem_space;
		logic       fw_mode;
		logic       fw_per_range;
		logic [3:0] psel_en;
		logic [3:0][3:0]  psel_mask;
		logic [3:0][15:0] psel_base;
	} lipd_ext_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} lipd_io_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} lipd_mem_t;
endpackage
`default_nettype wire

//--- lipd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module lipd_decoder #(
	parameter logic [31:0] APIC_BASE  = 32'hfec00000,
	parameter logic [31:0] APIC_LEN   = 32'h00000fff,
	parameter logic [31:0] SPI_BASE   = 32'hfed00000,
	parameter logic [31:0] SPI_LEN    = 32'h00000fff,
	parameter logic [31:0] TRUST_BASE = 32'hfed40000,
	parameter logic [31:0] TRUST_LEN  = 32'h00000fff
) (
	input  wire logic                 clock_i,
	input  wire logic                 resetn_i,
	input  wire lipd_pkg::lipd_cfg_t  cfg_i,
	input  wire lipd_pkg::lipd_ext_t  ext_i,
	input  wire lipd_pkg::lipd_io_t   io_i,
	input  wire lipd_pkg::lipd_mem_t  mem_i,
	output logic [7:0]                cfg_rdata_o,
	output logic                      io_pos_o,
	output logic                      io_sub_o,
	output logic                      mem_pos_o,
	output logic                      mem_fwd_o,
	output logic [3:0]                fw_sel_o,
	output logic                      timer_hit_o,
	output logic [15:0]               subsys_vendor_o,
	output logic [15:0]               subsys_id_o
);
	import lipd_pkg::*;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	typedef struct packed {
		logic [7:0]  tctrl;
		logic [21:0] tbase;
		logic [7:0]  c1;
		logic [7:0]  c2;
		logic [7:0]  c3;
		logic [7:0]  c4;
		logic [15:0] svid;
		logic [15:0] sid;
		logic [7:0]  romsel;
		logic [4:0][7:0] fw;
		logic [3:0]  fw6_lo;
		logic [7:0]  rdata;
		logic        io_pos;
		logic        io_sub;
		logic        mem_pos;
		logic        mem_fwd;
		logic [3:0]  fw_sel;
		logic        timer_hit;
	} lipd_state_t;

	lipd_state_t state_reg;
	lipd_state_t state_next;

	function automatic logic in_io(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic logic in_mem(input logic [31:0] a,
		input logic [31:0] lo, input logic [31:0] len);
		return (a >= lo) && (a <= lo + len);
	endfunction

	function automatic logic psel_hit(input logic [15:0] a,
		input logic [15:0] base, input logic [3:0] mask,
		input logic wide);
		logic [15:0] diff;
		diff = a ^ base;
		if (wide) begin
			return diff[15:8] == 8'h00;
		end
		return (diff & ~{12'h000, mask}) == 16'h0000;
	endfunction

	function automatic logic [3:0] nib(input logic [7:0] b,
		input logic hi);
		return hi ? b[7:4] : b[3:0];
	endfunction

	// Combinational hit terms
	logic [3:0]  psel_range;
	logic [3:0]  psel_pos_en;
	logic        io_any_pos;
	logic        rom_1m;
	logic        rom_512k;
	logic        rom_legacy;
	logic        rom_sel_hit;
	logic [3:0]  fw_pair;
	logic [15:0] ioa;
	logic [31:0] ma;
	logic [3:0]  fw6;

	assign ioa = io_i.addr;
	assign ma  = mem_i.addr;
	assign fw6 = FW6_HI_RO;

	assign psel_pos_en = {state_reg.c4[C4_PSEL23], state_reg.c4[C4_PSEL23],
		state_reg.c1[C1_PSEL1], state_reg.c1[C1_PSEL0]};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_psel
			assign psel_range[gi] = ext_i.psel_en[gi] &&
				psel_hit(ioa, ext_i.psel_base[gi], ext_i.psel_mask[gi],
				state_reg.tctrl[gi]);
		end
	endgenerate

	always_comb begin
		logic [1:0] mss;
		logic [1:0] par;
		logic [1:0] midi;
		logic [1:0] snd;
		logic [15:0] flop;
		logic [15:0] sndb;
		mss  = state_reg.c1[C1_MSS_LO +: 2];
		par  = state_reg.c2[C2_PAR_LO +: 2];
		midi = state_reg.c2[C2_MIDI_LO +: 2];
		snd  = state_reg.c4[C4_SND_LO +: 2];
		flop = state_reg.c4[C4_FLOPSEC] ? FLOP_SEC : FLOP_PRI;
		sndb = SND_BASE + {8'h00, 1'b0, snd, 5'h00};
		io_any_pos = 1'b0;
		if (|(psel_range & psel_pos_en)) begin
			io_any_pos = 1'b1;
		end
		if (state_reg.c1[C1_ONBOARD] && ioa <= ONBOARD_HI) begin
			io_any_pos = 1'b1;
		end
		if (state_reg.c1[C1_MSS_EN] &&
			in_io(ioa, MSS_BASE[mss], MSS_BASE[mss] + MSS_LEN)) begin
			io_any_pos = 1'b1;
		end
		if (state_reg.c2[C2_FLOPPY] && in_io(ioa, flop, flop + FLOP_LEN))
		begin
			io_any_pos = 1'b1;
		end
		// parallel ranges, code 11 decodes nothing
		if (state_reg.c2[C2_PAR_EN] && par != PAR_RSVD) begin
			if (in_io(ioa, PAR_LO_A[par], PAR_HI_A[par]) ||
				in_io(ioa, PAR_LO_B[par], PAR_HI_B[par])) begin
				io_any_pos = 1'b1;
			end
		end
		if (state_reg.c2[C2_GAME] && in_io(ioa, GAME_LO, GAME_HI)) begin
			io_any_pos = 1'b1;
		end
		if (state_reg.c2[C2_MIDI_EN] && in_io(ioa,
			MIDI_BASE + {10'h000, midi, 4'h0},
			MIDI_BASE + {10'h000, midi, 4'h0} + MIDI_LEN)) begin
			io_any_pos = 1'b1;
		end
		if (state_reg.c3[C3_SERB_EN] && in_io(ioa,
			SER_BASE[state_reg.c3[C3_SERB_LO +: 3]],
			SER_BASE[state_reg.c3[C3_SERB_LO +: 3]] + SER_LEN)) begin
			io_any_pos = 1'b1;
		end
		if (state_reg.c3[C3_SERA_EN] && in_io(ioa,
			SER_BASE[state_reg.c3[C3_SERA_LO +: 3]],
			SER_BASE[state_reg.c3[C3_SERA_LO +: 3]] + SER_LEN)) begin
			io_any_pos = 1'b1;
		end
		if (state_reg.c4[C4_RSTPORT] && ioa == RSTPORT) begin
			io_any_pos = 1'b1;
		end
		if (state_reg.c4[C4_SND_EN] && (in_io(ioa, sndb, sndb + SND_LEN_A)
			|| in_io(ioa, sndb + SND_OFS_B, sndb + SND_OFS_B + SND_LEN_B)))
		begin
			io_any_pos = 1'b1;
		end
	end

	assign rom_1m      = ma[31:24] == ROM_TOP && !ma[23];
	assign rom_512k    = ma[31:24] == ROM_TOP && ma[23];
	assign rom_legacy  = ma[31:17] == LEGACY_HI;
	assign rom_sel_hit = rom_1m && state_reg.romsel[ma[21:20]];

	always_comb begin
		logic [2:0] idx;
		idx = rom_legacy ? 3'h7 : ma[21:19];
		fw_pair = 4'h0;
		if (ext_i.fw_mode && !ext_i.fw_per_range) begin
			fw_pair = state_reg.romsel[7:4];
		end else if (rom_1m) begin
			fw_pair = nib(state_reg.fw[ma[21]], ma[20]);
		end else if (rom_512k || rom_legacy) begin
			case (idx[2:1])
				2'h0: fw_pair = nib(state_reg.fw[2], idx[0]);
				2'h1: fw_pair = nib(state_reg.fw[3], idx[0]);
				2'h2: fw_pair = nib(state_reg.fw[4], idx[0]);
				2'h3: fw_pair = idx[0] ? fw6 : state_reg.fw6_lo;
				default: fw_pair = 4'h0;
			endcase
		end
	end

	always_comb begin
		state_next = state_reg;
		// Config writes; reserved bits never stored, so they read zero
		if (cfg_i.wr) begin
			case (cfg_i.addr)
				OFS_TCTRL:  state_next.tctrl = cfg_i.wdata & TCTRL_MASK;
				OFS_TBASE0: state_next.tbase[5:0] = cfg_i.wdata[7:2];
				OFS_TBASE1: state_next.tbase[13:6] = cfg_i.wdata;
				OFS_TBASE2: state_next.tbase[21:14] = cfg_i.wdata;
				OFS_CTRL1:  state_next.c1 = cfg_i.wdata;
				OFS_CTRL2:  state_next.c2 = cfg_i.wdata;
				OFS_CTRL3:  state_next.c3 = cfg_i.wdata;
				OFS_CTRL4:  state_next.c4 = cfg_i.wdata;
				OFS_SVID0:  state_next.svid[7:0] = cfg_i.wdata;
				OFS_SVID1:  state_next.svid[15:8] = cfg_i.wdata;
				OFS_SID0:   state_next.sid[7:0] = cfg_i.wdata;
				OFS_SID1:   state_next.sid[15:8] = cfg_i.wdata;
				OFS_ROMSEL: state_next.romsel = cfg_i.wdata;
				OFS_FW1:    state_next.fw[0] = cfg_i.wdata;
				OFS_FW2:    state_next.fw[1] = cfg_i.wdata;
				OFS_FW3:    state_next.fw[2] = cfg_i.wdata;
				OFS_FW4:    state_next.fw[3] = cfg_i.wdata;
				OFS_FW5:    state_next.fw[4] = cfg_i.wdata;
				OFS_FW6:    state_next.fw6_lo = cfg_i.wdata[3:0];
				default:    state_next.rdata = state_reg.rdata;
			endcase
		end
		// Read data is always presented for the addressed byte
		case (cfg_i.addr)
			OFS_TCTRL:  state_next.rdata = state_reg.tctrl;
			OFS_TBASE0: state_next.rdata = {state_reg.tbase[5:0], 2'b00};
			OFS_TBASE1: state_next.rdata = state_reg.tbase[13:6];
			OFS_TBASE2: state_next.rdata = state_reg.tbase[21:14];
			OFS_CTRL1:  state_next.rdata = state_reg.c1;
			OFS_CTRL2:  state_next.rdata = state_reg.c2;
			OFS_CTRL3:  state_next.rdata = state_reg.c3;
			OFS_CTRL4:  state_next.rdata = state_reg.c4;
			OFS_SVID0:  state_next.rdata = state_reg.svid[7:0];
			OFS_SVID1:  state_next.rdata = state_reg.svid[15:8];
			OFS_SID0:   state_next.rdata = state_reg.sid[7:0];
			OFS_SID1:   state_next.rdata = state_reg.sid[15:8];
			OFS_ROMSEL: state_next.rdata = state_reg.romsel;
			OFS_FW1:    state_next.rdata = state_reg.fw[0];
			OFS_FW2:    state_next.rdata = state_reg.fw[1];
			OFS_FW3:    state_next.rdata = state_reg.fw[2];
			OFS_FW4:    state_next.rdata = state_reg.fw[3];
			OFS_FW5:    state_next.rdata = state_reg.fw[4];
			OFS_FW6:    state_next.rdata = {fw6, state_reg.fw6_lo};
			default:    state_next.rdata = RST_BYTE;
		endcase
		state_next.io_pos = io_i.valid && ext_i.global_pos && io_any_pos;
		state_next.io_sub = io_i.valid && !state_next.io_pos;
		state_next.mem_pos = mem_i.valid && ext_i.global_pos && (
			(state_reg.c1[C1_ROM] && (rom_1m || rom_512k || rom_legacy)) ||
			(state_reg.c1[C1_APIC] && in_mem(ma, APIC_BASE, APIC_LEN)) ||
			(state_reg.c4[C4_SPI] && in_mem(ma, SPI_BASE, SPI_LEN)) ||
			(state_reg.c4[C4_TRUST] && in_mem(ma, TRUST_BASE, TRUST_LEN)));
		state_next.mem_fwd = mem_i.valid && (!ext_i.mem_space ||
			rom_sel_hit || rom_512k || rom_legacy);
		state_next.fw_sel = fw_pair;
		state_next.timer_hit = mem_i.valid && state_reg.tctrl[TCTRL_EN] &&
			ma[31:10] == state_reg.tbase;
		if (!resetn_i) begin
			state_next = '0;
		end
	end

	always_ff @(posedge clock_i) begin
		state_reg <= state_next;
	end

	assign cfg_rdata_o     = state_reg.rdata;
	assign io_pos_o        = state_reg.io_pos;
	assign io_sub_o        = state_reg.io_sub;
	assign mem_pos_o       = state_reg.mem_pos;
	assign mem_fwd_o       = state_reg.mem_fwd;
	assign fw_sel_o        = state_reg.fw_sel;
	assign timer_hit_o     = state_reg.timer_hit;
	assign subsys_vendor_o = state_reg.svid;
	assign subsys_id_o     = state_reg.sid;
	sequence s_io_cycle;
		io_i.valid && resetn_i;
	endsequence

	sequence s_wr(logic [7:0] a);
		cfg_i.wr && cfg_i.addr == a;
	endsequence

	a_onboard_claim: assert property (s_io_cycle ##0 (ext_i.global_pos &&
		state_reg.c1[C1_ONBOARD] && ioa <= ONBOARD_HI) |=> io_pos_o)
		else $error("on-board port not claimed");
	a_global_sub: assert property (s_io_cycle ##0 !ext_i.global_pos
		|=> io_sub_o && !io_pos_o)
		else $error("positive claim with global mode off");
	a_psel_sub: assert property ((s_io_cycle ##0 (|psel_range) &&
		!(|(psel_range & psel_pos_en)) && !io_any_pos) |=> io_sub_o)
		else $error("select range not left subtractive");
	a_claim_excl: assert property (io_pos_o |-> !io_sub_o &&
		$past(io_i.valid) && $past(io_any_pos))
		else $error("positive claim without enabled hit");
	a_timer_hit: assert property (mem_i.valid &&
		state_reg.tctrl[TCTRL_EN] && ma[31:10] == state_reg.tbase
		|=> timer_hit_o)
		else $error("timer window missed");
	a_base_low: assert property (s_wr(OFS_TBASE0) ##1
		!cfg_i.wr && cfg_i.addr == OFS_TBASE0 |=> cfg_rdata_o ==
		{$past(cfg_i.wdata[7:2], 2), 2'b00})
		else $error("reserved base bits read nonzero");
	a_fw6_ro: assert property (s_wr(OFS_FW6) ##1
		cfg_i.addr == OFS_FW6 |=> cfg_rdata_o[7:4] == FW6_HI_RO &&
		cfg_rdata_o[3:0] == $past(cfg_i.wdata[3:0], 2))
		else $error("firmware select six nibbles wrong");
	a_fw_global: assert property (ext_i.fw_mode &&
		!ext_i.fw_per_range |=> fw_sel_o == $past(state_reg.romsel[7:4]))
		else $error("global device select not applied");
	a_fwd_all: assert property (mem_i.valid && !ext_i.mem_space
		|=> mem_fwd_o)
		else $error("memory cycle not forwarded");
	a_fwd_filter: assert property (mem_i.valid && ext_i.mem_space &&
		rom_1m && !state_reg.romsel[ma[21:20]] |=> !mem_fwd_o)
		else $error("unselected rom range forwarded");
	a_backdoor: assert property (s_wr(OFS_SVID0) |=>
		subsys_vendor_o[7:0] == $past(cfg_i.wdata))
		else $error("vendor back-door not stored");
endmodule // lipd_decoder
`default_nettype wire

//--- lipd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module lipd_far_model (
	input  wire logic                clock_i,
	output var  lipd_pkg::lipd_io_t  io_o,
	output var  lipd_pkg::lipd_mem_t mem_o
);
	import lipd_pkg::*;

	initial begin
		io_o = '{valid: 1'b0, addr: 16'h0000};
		mem_o = '{valid: 1'b0, addr: 32'h0000_0000};
	end

	// Host cycles last one clock, launched off the falling edge
	task automatic io_cycle(input logic [15:0] a);
		@(negedge clock_i);
		io_o = '{valid: 1'b1, addr: a};
		@(negedge clock_i);
		// Released address idles inverted, never the stale value
		io_o = '{valid: 1'b0, addr: ~a};
	endtask

	task automatic mem_cycle(input logic [31:0] a);
		@(negedge clock_i);
		mem_o = '{valid: 1'b1, addr: a};
		@(negedge clock_i);
		mem_o = '{valid: 1'b0, addr: ~a};
	endtask
endmodule // lipd_far_model
`default_nettype wire

//--- legacy_io_positive_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module legacy_io_positive_decoder_tb_top;
	import lipd_pkg::*;
	typedef struct packed {
		logic [6:0] val;
		logic [6:0] msk;
	} lipd_mexp_t;
	localparam logic [6:0] MF = 7'h40;
	localparam logic [6:0] MS = 7'h1e;
	localparam logic [6:0] MT = 7'h01;
	logic        clock_i = 1'b0;
	logic        resetn_i = 1'b0;
	lipd_cfg_t   cfg = '0;
	lipd_ext_t   ext = '0;
	lipd_io_t    io_bus;
	lipd_mem_t   mem_bus;
	logic [7:0]  rdata;
	logic        io_pos, io_sub, mem_pos, mem_fwd, timer_hit;
	logic [3:0]  fw_sel;
	logic [15:0] svid, sid;
	logic [1:0]  io_q [$];
	lipd_mexp_t  mem_q [$];
	logic [7:0]  rd_q [$];
	logic        rd_pend = 1'b0;
	logic        f_io, f_mem, f_rd;
	int          err_count = 0;
	int          checks_done = 0;
	logic [31:0] seed = 32'h4ebf3b9e;
	logic [7:0]  d, e;
	logic [7:0]  img [24];
	logic [21:0] tb;
	logic [15:0] ser [8] = '{16'h03f8, 16'h02f8, 16'h0220, 16'h0228,
		16'h0238, 16'h02e8, 16'h0338, 16'h03e8};
	logic [15:0] mss [4] = '{16'h0530, 16'h0604, 16'h0e80, 16'h0f40};
	logic [15:0] par [3] = '{16'h07be, 16'h077a, 16'h067a};
	logic [3:0]  pmsk [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};

	always #50 clock_i = ~clock_i;

	lipd_far_model far (.clock_i(clock_i), .io_o(io_bus), .mem_o(mem_bus));
	lipd_decoder uut (.clock_i(clock_i), .resetn_i(resetn_i), .cfg_i(cfg),
		.ext_i(ext), .io_i(io_bus), .mem_i(mem_bus), .cfg_rdata_o(rdata),
		.io_pos_o(io_pos), .io_sub_o(io_sub), .mem_pos_o(mem_pos),
		.mem_fwd_o(mem_fwd), .fw_sel_o(fw_sel), .timer_hit_o(timer_hit),
		.subsys_vendor_o(svid), .subsys_id_o(sid));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cfg_wr(input logic [7:0] a, dat);
		@(negedge clock_i);
		cfg = '{wr: 1'b1, addr: a, wdata: dat};
		@(negedge clock_i);
		cfg.wr = 1'b0;
	endtask

	task automatic cfg_rd(input logic [7:0] a, ex);
		@(negedge clock_i);
		cfg.addr = a;
		rd_q.push_back(ex);
		rd_pend = 1'b1;
		@(negedge clock_i);
		rd_pend = 1'b0;
	endtask

	task automatic io(input logic [15:0] a, input logic p);
		io_q.push_back({p, ~p});
		far.io_cycle(a);
	endtask

	task automatic mem(input logic [31:0] a, input logic [6:0] v, m);
		mem_q.push_back('{val: v, msk: m});
		far.mem_cycle(a);
	endtask

	task automatic field(input logic [7:0] ofs, val, en,
		input logic [15:0] hit, miss);
		cfg_wr(ofs, val & ~en);
		io(hit, 1'b0);
		cfg_wr(ofs, val);
		io(hit, 1'b1);
		io(miss, 1'b0);
		cfg_wr(ofs, 8'h00);
	endtask

	// Results land one edge after their request
	always @(posedge clock_i) begin
		f_io = io_bus.valid;
		f_mem = mem_bus.valid;
		f_rd = rd_pend;
		#1;
		if (f_io && io_q.size() > 0)
			check("io claim", {14'h0, io_pos, io_sub}, {14'h0, io_q.pop_front()});
		if (f_rd && rd_q.size() > 0)
			check("config read", {8'h0, rdata}, {8'h0, rd_q.pop_front()});
		if (f_mem && mem_q.size() > 0) begin
			check("mem decode", {9'h0, {mem_fwd, mem_pos, fw_sel, timer_hit} & mem_q[0].msk}, {9'h0, mem_q[0].val & mem_q[0].msk});
			void'(mem_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		err_count++;
		wrap_up();
	end

	initial begin
		ext.global_pos = 1'b1;
		repeat (20) @(negedge clock_i);
		resetn_i = 1'b1;
		for (int a = 8'h68; a < 8'h80; a++)
			cfg_rd(8'(a), 8'h00);
		for (int a = 8'h68; a < 8'h80; a++) begin
			d = 8'(rnd());
			cfg_wr(8'(a), d);
			e = (a == 8'h68) ? (d & 8'h8f) : (a == 8'h69) ? (d & 8'hfc) :
				(a == 8'h7f) ? (d & 8'h0f) :
				(a == 8'h74 || (a > 8'h77 && a < 8'h7c)) ? 8'h00 : d;
			img[a - 8'h68] = e;
			cfg_rd(8'(a), e);
		end
		check("vendor id", svid, {img[9], img[8]});
		check("subsys id", sid, {img[11], img[10]});
		// Mid-run reset must clear every stored byte
		resetn_i = 1'b0;
		repeat (2) @(negedge clock_i);
		resetn_i = 1'b1;
		check("vendor id", svid, 16'h0000);
		for (int a = 8'h68; a < 8'h80; a++)
			cfg_rd(8'(a), 8'h00);
		for (int a = 8'h68; a < 8'h80; a++)
			cfg_wr(8'(a), 8'h00);
		repeat (8) io(16'(rnd()), 1'b0);
		field(8'h6c, 8'h80, 8'h80, 16'h00ff, 16'h0100);
		for (int c = 0; c < 4; c++) begin
			field(8'h6c, 8'(8'h40 | c << 4), 8'h40, mss[c] + 16'h7, mss[c] + 16'h8);
			field(8'h6d, 8'(8'h04 | c), 8'h04, 16'(16'h0303 + c * 16), 16'(16'h0304 + c * 16));
			field(8'h6f, 8'(8'h04 | c), 8'h04, 16'(16'h0233 + c * 32), 16'(16'h0234 + c * 32));
		end
		for (int c = 0; c < 3; c++)
			field(8'h6d, 8'(8'h40 | c << 4), 8'h40, par[c], par[c] + 16'h1);
		cfg_wr(8'h6d, 8'h70);
		io(16'h03bc, 1'b0);
		for (int c = 0; c < 8; c++) begin
			field(8'h6e, 8'(8'h80 | c << 4), 8'h80, ser[c], ser[c] + 16'h8);
			field(8'h6e, 8'(8'h08 | c), 8'h08, ser[c] + 16'h7, ser[c] - 16'h1);
		end
		field(8'h6d, 8'h80, 8'h80, 16'h03f7, 16'h0377);
		cfg_wr(8'h6f, 8'h08);
		field(8'h6d, 8'h80, 8'h80, 16'h0370, 16'h03f0);
		field(8'h6d, 8'h08, 8'h08, 16'h0207, 16'h0208);
		field(8'h6f, 8'h10, 8'h10, 16'h0cf9, 16'h0cf8);
		cfg_wr(8'h6c, 8'h80);
		ext.global_pos = 1'b0;
		io(16'h0010, 1'b0);
		ext.global_pos = 1'b1;
		for (int k = 0; k < 5; k++) begin
			ext.psel_base[k % 4] = 16'h0400;
			ext.psel_mask[k % 4] = pmsk[k];
			ext.psel_en[k % 4] = 1'b1;
			cfg_wr(8'h6c, (k % 4) < 2 ? 8'(1 << k % 4) : 8'h00);
			cfg_wr(8'h6f, 8'h20);
			io(16'(16'h03ff + (1 << k)), 1'b1);
			io(16'(16'h0400 + (1 << k)), 1'b0);
			cfg_wr(8'h68, 8'(1 << k % 4));
			io(16'h04ff, 1'b1);
			io(16'h0500, 1'b0);
			cfg_wr(8'h6c, 8'h00);
			cfg_wr(8'h6f, 8'h00);
			io(16'h0400, 1'b0);
			cfg_wr(8'h68, 8'h00);
			ext.psel_en = 4'h0;
		end
		repeat (4) mem(rnd(), MF, MF);
		ext.mem_space = 1'b1;
		mem(32'h1000_0000, 7'h00, MF);
		for (int b = 0; b < 4; b++) begin
			cfg_wr(8'h75, 8'(1 << b));
			mem(32'hff00_0000 | b << 20, MF, MF);
			mem(32'hff40_0000 | b << 20, MF, MF);
			mem(32'hff40_0000 | (b ^ 1) << 20, 7'h00, MF);
		end
		cfg_wr(8'h76, 8'h21);
		cfg_wr(8'h77, 8'h43);
		cfg_wr(8'h7c, 8'h65);
		cfg_wr(8'h7f, 8'hff);
		for (int b = 0; b < 4; b++)
			mem(32'hff00_0000 | b << 20, {2'b00, 4'(b + 1), 1'b0}, MS);
		mem(32'hff80_0000, 7'h0a, MS);
		mem(32'hffc8_0000, 7'h0c, MS);
		mem(32'hfff0_0000, 7'h1e, MS);
		mem(32'h000e_0000, 7'h00, MS);
		ext.fw_mode = 1'b1;
		cfg_wr(8'h75, 8'ha0);
		mem(32'hff00_0000, 7'h14, MS);
		ext.fw_per_range = 1'b1;
		mem(32'hff00_0000, 7'h02, MS);
		// Positive memory claims, default window parameters
		cfg_wr(8'h6c, 8'h04);
		mem(32'hfff0_0000, 7'h20, 7'h20);
		mem(32'hfed0_0000, 7'h00, 7'h20);
		cfg_wr(8'h6f, 8'h80);
		mem(32'hfed0_0000, 7'h20, 7'h20);
		ext.global_pos = 1'b0;
		mem(32'hfff0_0000, 7'h00, 7'h20);
		ext.global_pos = 1'b1;
		cfg_wr(8'h6c, 8'h00);
		cfg_wr(8'h6f, 8'h00);
		tb = 22'(rnd());
		cfg_wr(8'h69, {tb[5:0], 2'b00});
		cfg_wr(8'h6a, tb[13:6]);
		cfg_wr(8'h6b, tb[21:14]);
		cfg_wr(8'h68, 8'h80);
		mem({tb, 10'h000}, MT, MT);
		mem({tb, 10'h000} - 32'h1, 7'h00, MT);
		cfg_wr(8'h68, 8'h00);
		mem({tb, 10'h000}, 7'h00, MT);
		for (int i = 0; i < 10; i++)
			if (io_q.size() + mem_q.size() + rd_q.size() > 0)
				@(posedge clock_i);
		if (io_q.size() + mem_q.size() + rd_q.size() > 0)
			err_count++;
		wrap_up();
	end
endmodule // legacy_io_positive_decoder_tb_top
`default_nettype wire
